// ===== hdl/mbc_media_block_coprocessor.sv
// How it works
// - Transform direction, quantize, dequantize, reorder and level shift are selectable per start, for every block of that run.
// - Eight-bit mode: forward 8 in, 11 out; inverse 11 in, 8 out.
// - Nine-bit mode: forward 9 in, 12 out; inverse 12 in, 9 out.
// - Input and output each choose sequential or zigzag order by configuration.
// - Level shift and inverse level shift share one software enable, ls_en, applied by direction.
// - Every quantize or dequantize pass uses one of four software-chosen tables.
// - Quantization multiplies by a stored reciprocal; no divider exists.
// - Two buffers of 512 sixteen-bit entries alternate between engine and port.
// - The engine works one buffer while the port fills the other.
// - Interrupt after a programmed count of blocks, one to eight.
// - Status reads at any time without disturbing processing.
// - One block completes within three microseconds of its start.
// - Data port words are 32 bits holding two 16-bit samples.
// - Buffers are reached over the plain register port, no special channel.
// - The block never holds the bus; it answers every access in the next cycle.
module mbc_media_block_coprocessor (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [mbc_pkg::MBC_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic irq_out
);

	// ==================================================
	// Helper functions
	function automatic logic [383:0] zz_build();
		logic [383:0] t;
		int r;
		int c;
		t = '0;
		r = 0;
		c = 0;
		for (int k = 0; k < 64; k++) begin
			t[k*6 +: 6] = 6'(r * 8 + c);
			if (((r + c) % 2) == 0) begin
				if (c == 7) r = r + 1;
				else if (r == 0) c = c + 1;
				else begin
					r = r - 1;
					c = c + 1;
				end
			end else begin
				if (r == 7) c = c + 1;
				else if (c == 0) r = r + 1;
				else begin
					r = r + 1;
					c = c - 1;
				end
			end
		end
		return t;
	endfunction

	function automatic logic [383:0] zz_invert(input logic [383:0] t);
		logic [383:0] inv;
		inv = '0;
		for (int k = 0; k < 64; k++) begin
			inv[int'(t[k*6 +: 6]) * 6 +: 6] = 6'(k);
		end
		return inv;
	endfunction

	// Scaled cosine basis; f is frequency index, s is spatial index
	function automatic logic signed [13:0] coef(input int f, input int s);
		int m;
		int v;
		logic neg;
		m = ((2 * s + 1) * f) % 32;
		if (m > 16) m = 32 - m;
		neg = (m > 8);
		if (neg) m = 16 - m;
		v = mbc_pkg::MBC_COS[m];
		if (f == 0) v = mbc_pkg::MBC_COS[4];
		return 14'(neg ? -v : v);
	endfunction

	function automatic logic signed [35:0] maxs(input int w);
		return (36'sh1 <<< (w - 1)) - 36'sh1;
	endfunction

	function automatic logic signed [35:0] clamp(input logic signed [35:0] v,
			input logic signed [35:0] lo, input logic signed [35:0] hi);
		return (v > hi) ? hi : ((v < lo) ? lo : v);
	endfunction

	function automatic logic signed [35:0] sext(input logic [15:0] d, input int w);
		logic [15:0] t;
		logic signed [35:0] x;
		t = d << (16 - w);
		x = 36'(signed'(t));
		return x >>> (16 - w);
	endfunction

	// Dequantize one coefficient with table value q
	function automatic logic signed [35:0] dequant(input logic signed [35:0] c,
			input logic [15:0] q, input logic [1:0] kind);
		logic signed [35:0] qq;
		logic signed [35:0] mag;
		logic signed [35:0] r;
		qq = 36'(q);
		mag = (c < 0) ? -c : c;
		r = (2 * mag + 36'sh1) * qq;
		if (kind == mbc_pkg::MBC_QK_H263) begin
			if (!q[0]) r = r - 36'sh1;
		end else begin
			r = r >>> mbc_pkg::MBC_MPEG4_SHIFT;
		end
		if (kind == mbc_pkg::MBC_QK_JPEG) return c * qq;
		if (c == 0) return '0;
		return (c < 0) ? -r : r;
	endfunction

	localparam logic [383:0] ZZ_INV = zz_invert(zz_build());

	// ==================================================
	// State
	logic [15:0] mem [2][mbc_pkg::MBC_BUF_DEPTH];
	logic [15:0] qtab [mbc_pkg::MBC_NUM_QTAB][64];
	logic signed [21:0] tmp [64];
	mbc_pkg::mbc_cfg_s cfg;
	mbc_pkg::mbc_cfg_s run;
	mbc_pkg::mbc_state_e state;
	logic [2:0] step;
	logic [2:0] blk;
	logic [3:0] blocks_done;
	logic host_sel;
	logic eng_sel;
	logic [8:0] dptr;
	logic [7:0] qaddr;
	logic [1:0] mask;
	logic [1:0] events;
	logic [1:0] ev;
	logic [1:0] next_events;
	logic [31:0] next_rdata;
	logic wr_ctrl;
	logic start_req;
	logic swap_req;
	logic abort_req;
	logic last_step;
	logic signed [35:0] vin [8];
	logic signed [35:0] vout [8];
	logic [8:0] waddr [8];
	logic [15:0] wdat [8];

	assign eng_sel = ~host_sel;
	assign wr_ctrl = reg_wr_in && (reg_addr_in == mbc_pkg::MBC_OFF_CTRL);
	assign start_req = wr_ctrl && reg_wdata_in[mbc_pkg::MBC_CTRL_START];
	assign swap_req = wr_ctrl && reg_wdata_in[mbc_pkg::MBC_CTRL_SWAP];
	assign abort_req = wr_ctrl && reg_wdata_in[mbc_pkg::MBC_CTRL_ABORT];
	assign last_step = (step == 3'h7);

	// ==================================================
	// Datapath: one row or column of eight per cycle
	always_comb begin
		logic [5:0] nat;
		logic [5:0] pos;
		logic signed [35:0] acc;
		logic signed [35:0] v;
		logic signed [35:0] off;
		int iw;
		int cw;
		nat = '0;
		pos = '0;
		acc = '0;
		v = '0;
		iw = run.nine ? mbc_pkg::MBC_W9_IN : mbc_pkg::MBC_W8_IN;
		cw = run.nine ? mbc_pkg::MBC_W9_COEF : mbc_pkg::MBC_W8_COEF;
		off = 36'sh1 <<< (iw - 1);
		for (int i = 0; i < 8; i++) begin
			vin[i] = '0;
			vout[i] = '0;
			waddr[i] = '0;
			wdat[i] = '0;
		end
		for (int i = 0; i < 8; i++) begin
			if (state == mbc_pkg::MBC_ROWS) begin
				nat = {step, 3'(i)};
				pos = run.in_zz ? ZZ_INV[int'(nat) * 6 +: 6] : nat;
				v = 36'(mem[eng_sel][{blk, pos}]);
				if (!run.decode) begin
					if (run.ls_en) v = (v & maxs(iw + 1)) - off;
					else v = sext(v[15:0], iw);
				end else begin
					v = sext(v[15:0], cw);
					if (run.q_en) begin
						v = dequant(v, qtab[run.qtab][nat], run.q_kind);
						v = clamp(v, -maxs(cw) - 36'sh1, maxs(cw));
					end
				end
				vin[i] = v;
			end else begin
				vin[i] = 36'(tmp[{3'(i), step}]);
			end
		end
		for (int o = 0; o < 8; o++) begin
			acc = '0;
			for (int i = 0; i < 8; i++) begin
				acc = acc + vin[i] * 36'(run.decode ? coef(i, o) : coef(o, i));
			end
			nat = {3'(o), step};
			if (state == mbc_pkg::MBC_ROWS) begin
				vout[o] = acc >>> mbc_pkg::MBC_ROW_SHIFT;
			end else begin
				v = acc >>> mbc_pkg::MBC_COL_SHIFT;
				if (!run.decode) begin
					v = clamp(v, -maxs(cw) - 36'sh1, maxs(cw));
					if (run.q_en) begin
						v = (v * 36'(qtab[run.qtab][nat])) >>> mbc_pkg::MBC_Q_SHIFT;
					end
				end else if (run.ls_en) begin
					v = clamp(v + off, '0, maxs(iw + 1));
				end else begin
					v = clamp(v, -maxs(iw) - 36'sh1, maxs(iw));
				end
				vout[o] = v;
			end
			pos = run.out_zz ? ZZ_INV[int'(nat) * 6 +: 6] : nat;
			waddr[o] = {blk, pos};
			wdat[o] = vout[o][15:0];
		end
	end

	// ==================================================
	// Row pass results
	always_ff @(posedge ref_clk_in) begin
		if (state == mbc_pkg::MBC_ROWS) begin
			for (int o = 0; o < 8; o++) begin
				tmp[{step, 3'(o)}] <= vout[o][21:0];
			end
		end
	end

	// ==================================================
	// Buffers and tables
	always_ff @(posedge ref_clk_in) begin
		if (reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_DATA) begin
			mem[host_sel][dptr] <= reg_wdata_in[15:0];
			mem[host_sel][dptr | 9'h001] <= reg_wdata_in[31:16];
		end
		if (state == mbc_pkg::MBC_COLS) begin
			for (int o = 0; o < 8; o++) begin
				mem[eng_sel][waddr[o]] <= wdat[o];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_QDATA) begin
			qtab[qaddr[7:6]][qaddr[5:0]] <= reg_wdata_in[15:0];
		end
	end

	// ==================================================
	// Pointers
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dptr <= 9'h000;
		end else if (reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_DPTR) begin
			dptr <= {reg_wdata_in[8:1], 1'b0};
		end else if ((reg_wr_in || reg_rd_in) && reg_addr_in == mbc_pkg::MBC_OFF_DATA) begin
			dptr <= dptr + 9'h002;
		end else if ((start_req || swap_req) && state == mbc_pkg::MBC_IDLE) begin
			dptr <= 9'h000;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			qaddr <= 8'h00;
		end else if (reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_QADDR) begin
			qaddr <= reg_wdata_in[7:0];
		end else if (reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_QDATA) begin
			qaddr <= qaddr + 8'h01;
		end
	end

	// ==================================================
	// Configuration and mask
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg <= mbc_pkg::MBC_CFG_RESET;
			mask <= mbc_pkg::MBC_MASK_RESET;
		end else if (reg_wr_in) begin
			if (reg_addr_in == mbc_pkg::MBC_OFF_CFG) cfg <= reg_wdata_in[12:0];
			if (reg_addr_in == mbc_pkg::MBC_OFF_MASK) begin
				mask <= reg_wdata_in[mbc_pkg::MBC_EV_LSB +: mbc_pkg::MBC_EV_W];
			end
		end
	end

	// ==================================================
	// Engine sequencer
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= mbc_pkg::MBC_IDLE;
			step <= 3'h0;
			blk <= 3'h0;
			blocks_done <= 4'h0;
			host_sel <= 1'b0;
			run <= mbc_pkg::MBC_CFG_RESET;
		end else if (abort_req) begin
			state <= mbc_pkg::MBC_IDLE;
			step <= 3'h0;
		end else begin
			unique case (state)
				mbc_pkg::MBC_IDLE: begin
					if (start_req || swap_req) begin
						host_sel <= ~host_sel;
						blk <= 3'h0;
						step <= 3'h0;
					end
					if (start_req) begin
						run <= cfg;
						blocks_done <= 4'h0;
						state <= mbc_pkg::MBC_ROWS;
					end
				end
				mbc_pkg::MBC_ROWS: begin
					step <= step + 3'h1;
					if (last_step) state <= mbc_pkg::MBC_COLS;
				end
				mbc_pkg::MBC_COLS: begin
					step <= step + 3'h1;
					if (last_step) begin
						blocks_done <= blocks_done + 4'h1;
						blk <= blk + 3'h1;
						if (blk == run.blocks_m1) state <= mbc_pkg::MBC_IDLE;
						else state <= mbc_pkg::MBC_ROWS;
					end
				end
			endcase
		end
	end

	// ==================================================
	// Events, sticky status and interrupt
	always_comb begin
		ev = 2'h0;
		ev[mbc_pkg::MBC_EV_DONE] = (state == mbc_pkg::MBC_COLS) && last_step
			&& (blk == run.blocks_m1) && !abort_req;
		ev[mbc_pkg::MBC_EV_REFUSED] = (start_req || swap_req) && (state != mbc_pkg::MBC_IDLE);
		next_events = events;
		if (reg_rd_in && reg_addr_in == mbc_pkg::MBC_OFF_STATUS) next_events = 2'h0;
		next_events = next_events | ev;
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			events <= 2'h0;
			irq_out <= 1'b0;
		end else begin
			events <= next_events;
			irq_out <= |(next_events & mask);
		end
	end

	// ==================================================
	// Register read port, answer in the next cycle
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (reg_addr_in)
			mbc_pkg::MBC_OFF_CFG: next_rdata = 32'(cfg);
			mbc_pkg::MBC_OFF_STATUS: begin
				next_rdata[mbc_pkg::MBC_ST_BUSY] = (state != mbc_pkg::MBC_IDLE);
				next_rdata[mbc_pkg::MBC_ST_HOST_SEL] = host_sel;
				next_rdata[mbc_pkg::MBC_EV_LSB +: mbc_pkg::MBC_EV_W] = events;
			end
			mbc_pkg::MBC_OFF_MASK: next_rdata[mbc_pkg::MBC_EV_LSB +: mbc_pkg::MBC_EV_W] = mask;
			mbc_pkg::MBC_OFF_DPTR: next_rdata = 32'(dptr);
			mbc_pkg::MBC_OFF_DATA: next_rdata = {mem[host_sel][dptr | 9'h001],
				mem[host_sel][dptr]};
			mbc_pkg::MBC_OFF_QADDR: next_rdata = 32'(qaddr);
			mbc_pkg::MBC_OFF_QDATA: next_rdata = 32'(qtab[qaddr[7:6]][qaddr[5:0]]);
			mbc_pkg::MBC_OFF_BLKDONE: next_rdata = 32'(blocks_done);
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= next_rdata;
		end else begin
			reg_rdata_out <= 32'h0000_0000;
		end
	end

endmodule

// ===== hdl/mbc_pkg.sv
package mbc_pkg;

	// ==================================================
	// Register map (byte addresses, one word each)
	localparam int MBC_ADDR_W = 8;
	localparam logic [7:0] MBC_OFF_CTRL = 8'h00;
	localparam logic [7:0] MBC_OFF_CFG = 8'h04;
	localparam logic [7:0] MBC_OFF_STATUS = 8'h08;
	localparam logic [7:0] MBC_OFF_MASK = 8'h0C;
	localparam logic [7:0] MBC_OFF_DPTR = 8'h10;
	localparam logic [7:0] MBC_OFF_DATA = 8'h14;
	localparam logic [7:0] MBC_OFF_QADDR = 8'h18;
	localparam logic [7:0] MBC_OFF_QDATA = 8'h1C;
	localparam logic [7:0] MBC_OFF_BLKDONE = 8'h20;

	// ==================================================
	// Field positions
	localparam int MBC_CTRL_START = 0;
	localparam int MBC_CTRL_SWAP = 1;
	localparam int MBC_CTRL_ABORT = 2;
	localparam int MBC_ST_BUSY = 0;
	localparam int MBC_ST_HOST_SEL = 1;
	localparam int MBC_EV_LSB = 8;
	localparam int MBC_EV_W = 2;
	localparam int MBC_EV_DONE = 0;
	localparam int MBC_EV_REFUSED = 1;

	// ==================================================
	// Reset values
	localparam logic [12:0] MBC_CFG_RESET = 13'h0000;
	localparam logic [1:0] MBC_MASK_RESET = 2'h0;

	// ==================================================
	// Sizes, widths and arithmetic scaling
	localparam int MBC_BUF_DEPTH = 512;
	localparam int MBC_NUM_QTAB = 4;
	localparam int MBC_W8_IN = 8;
	localparam int MBC_W8_COEF = 11;
	localparam int MBC_W9_IN = 9;
	localparam int MBC_W9_COEF = 12;
	localparam int MBC_ROW_SHIFT = 10;
	localparam int MBC_COL_SHIFT = 16;
	localparam int MBC_Q_SHIFT = 16;
	localparam int MBC_MPEG4_SHIFT = 4;
	localparam int MBC_COS [0:8] = '{4096, 4017, 3784, 3406, 2896, 2276, 1567, 799, 0};

	// ==================================================
	// Timing
	localparam int MBC_CLK_HZ = 10_000_000;
	localparam int MBC_BLOCK_TIME_NS = 3000;
	localparam int MBC_BLOCK_CYCLES = MBC_BLOCK_TIME_NS / (1_000_000_000 / MBC_CLK_HZ);

	// ==================================================
	// Types
	typedef enum logic [1:0] {MBC_QK_JPEG, MBC_QK_H263, MBC_QK_MPEG4, MBC_QK_RSVD} mbc_qkind_e;
	typedef enum {MBC_IDLE, MBC_ROWS, MBC_COLS} mbc_state_e;
	typedef struct packed {
		logic [2:0] blocks_m1;
		logic [1:0] qtab;
		logic [1:0] q_kind;
		logic q_en;
		logic ls_en;
		logic out_zz;
		logic in_zz;
		logic nine;
		logic decode;
	} mbc_cfg_s;

endpackage

// ===== testbench/mbc_chk_sva.sv
module mbc_chk (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [mbc_pkg::MBC_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic irq_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==================================================
	// Decoded accesses and register shadows
	wire logic st_rd = reg_rd_in && reg_addr_in == mbc_pkg::MBC_OFF_STATUS;
	wire logic mk_wr = reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_MASK;
	wire logic mk_rd = reg_rd_in && reg_addr_in == mbc_pkg::MBC_OFF_MASK;
	wire logic cf_wr = reg_wr_in && reg_addr_in == mbc_pkg::MBC_OFF_CFG;
	wire logic cf_rd = reg_rd_in && reg_addr_in == mbc_pkg::MBC_OFF_CFG;
	wire logic bd_rd = reg_rd_in && reg_addr_in == mbc_pkg::MBC_OFF_BLKDONE;
	wire logic un_rd = reg_rd_in && reg_addr_in > 8'h20;
	logic [1:0] mask_sh;
	logic [12:0] cfg_sh;

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mask_sh <= 2'h0;
		end else if (mk_wr) begin
			mask_sh <= reg_wdata_in[9:8];
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_sh <= 13'h0000;
		end else if (cf_wr) begin
			cfg_sh <= reg_wdata_in[12:0];
		end
	end

	// ==================================================
	// Properties
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data driven outside its slot");
	a_unmapped_zero: assert property ($past(un_rd) |-> reg_rdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_status_fields: assert property ($past(st_rd) |->
		(reg_rdata_out & 32'hFFFFFCFC) == 32'h0)
		else $error("status reserved bits set");
	a_blkdone_max: assert property ($past(bd_rd) |-> reg_rdata_out <= 32'd8)
		else $error("block count above eight");
	a_cfg_readback: assert property ($past(cf_rd) |->
		reg_rdata_out == {19'h0, $past(cfg_sh)})
		else $error("config read back wrong");
	a_mask_readback: assert property ($past(mk_rd) |->
		reg_rdata_out == {22'h0, $past(mask_sh), 8'h0})
		else $error("mask read back wrong");
	a_irq_masked: assert property (mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |->
		!irq_out)
		else $error("interrupt with all sources masked");
	a_irq_fall_cause: assert property ($fell(irq_out) |->
		$past(st_rd) || $past(st_rd, 2) || $past(mk_wr) || $past(mk_wr, 2))
		else $error("interrupt dropped without status read or mask write");
endmodule

// ===== testbench/mbc_host_model.sv
module mbc_host_model (
	input wire logic ref_clk_in,
	input wire logic [31:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [31:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==================================================
	// Host cycles on the plain register port
	initial begin
		addr_out = 8'h00;
		wdata_out = 32'h0;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_in);
		addr_out <= a;
		wdata_out <= v;
		wr_out <= 1'b1;
		@(posedge ref_clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~v;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge ref_clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1 v = rdata_in;
	endtask

	task automatic load_buf(input int n, input logic [31:0] v);
		wr_reg(mbc_pkg::MBC_OFF_DPTR, 32'h0);
		repeat (n) wr_reg(mbc_pkg::MBC_OFF_DATA, v);
	endtask

	task automatic load_qtab(input logic [1:0] t, input logic [15:0] v);
		wr_reg(mbc_pkg::MBC_OFF_QADDR, {24'h0, t, 6'h00});
		repeat (64) wr_reg(mbc_pkg::MBC_OFF_QDATA, {16'h0, v});
	endtask
endmodule

// ===== testbench/tb_mbc_media_block_coprocessor.sv
module tb_mbc_media_block_coprocessor;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_in;
	logic reset_n_in;
	logic [7:0] reg_addr_in;
	logic [31:0] reg_wdata_in;
	logic reg_wr_in;
	logic reg_rd_in;
	logic [31:0] reg_rdata_out;
	logic irq_out;
	logic [31:0] d;
	int fails;
	int n_tests;

	mbc_media_block_coprocessor dut_u (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.irq_out(irq_out)
	);

	mbc_host_model host_u (
		.ref_clk_in(ref_clk_in),
		.rdata_in(reg_rdata_out),
		.addr_out(reg_addr_in),
		.wdata_out(reg_wdata_in),
		.wr_out(reg_wr_in),
		.rd_out(reg_rd_in)
	);

	// ==================================================
	// Clock and watchdog
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		repeat (6000) @(posedge ref_clk_in);
		fails++;
		summarize();
	end

	// ==================================================
	// Checking tasks
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		host_u.rd_reg(a, d);
		chk(d, exp);
	endtask

	task automatic rd_buf(input int n, input logic [31:0] exp);
		host_u.wr_reg(mbc_pkg::MBC_OFF_DPTR, 32'h0);
		repeat (n) rd_chk(mbc_pkg::MBC_OFF_DATA, exp);
	endtask

	// Start, refuse a swap while busy, preload the free buffer, then collect
	task automatic run(input int nblk, input logic sel, input int nld, input logic [31:0] v);
		int k;
		k = 0;
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h1);
		host_u.rd_reg(mbc_pkg::MBC_OFF_STATUS, d);
		chk(d & 32'h3, {30'h0, sel, 1'b1});
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h2);
		fork
			while (irq_out !== 1'b1 && k < nblk * mbc_pkg::MBC_BLOCK_CYCLES) begin
				@(posedge ref_clk_in);
				k++;
			end
			host_u.load_buf(nld, v);
		join
		#1 chk({31'h0, irq_out}, 32'h1);
		rd_chk(mbc_pkg::MBC_OFF_BLKDONE, nblk);
		host_u.rd_reg(mbc_pkg::MBC_OFF_STATUS, d);
		chk(d & 32'h301, 32'h300);
		@(posedge ref_clk_in);
		#1 chk({31'h0, irq_out}, 32'h0);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h2);
	endtask

	// ==================================================
	// Test sequence
	initial begin
		fails = 0;
		n_tests = 0;
		reset_n_in = 1'b0;
		repeat (12) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		#1 chk({31'h0, irq_out}, 32'h0);
		rd_chk(mbc_pkg::MBC_OFF_CFG, 32'h0);
		rd_chk(mbc_pkg::MBC_OFF_MASK, 32'h0);
		rd_chk(mbc_pkg::MBC_OFF_STATUS, 32'h0);
		host_u.wr_reg(8'h40, 32'hFFFF_FFFF);
		rd_chk(8'h40, 32'h0);
		host_u.load_buf(64, 32'h0080_0080);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CFG, 32'h0410);
		host_u.wr_reg(mbc_pkg::MBC_OFF_MASK, 32'h0100);
		rd_chk(mbc_pkg::MBC_OFF_CFG, 32'h0410);
		run(2, 1'b1, 32, 32'h0);
		rd_buf(64, 32'h0);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h2);
		host_u.load_qtab(2'h1, 16'h0001);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CFG, 32'h0131);
		run(1, 1'b0, 32, 32'h0100_0100);
		rd_buf(32, 32'h0080_0080);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h2);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CFG, 32'h0012);
		run(1, 1'b1, 0, 32'h0);
		rd_buf(32, 32'h0);
		host_u.load_buf(32, 32'h0);
		host_u.wr_reg(mbc_pkg::MBC_OFF_DPTR, 32'h0);
		host_u.wr_reg(mbc_pkg::MBC_OFF_DATA, 32'h0000_002A);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CFG, 32'h017D);
		run(1, 1'b1, 0, 32'h0);
		rd_buf(32, 32'h008A_008A);
		host_u.wr_reg(mbc_pkg::MBC_OFF_MASK, 32'h0);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CFG, 32'h1C00);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h1);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h2);
		host_u.wr_reg(mbc_pkg::MBC_OFF_CTRL, 32'h4);
		#1 chk({31'h0, irq_out}, 32'h0);
		rd_chk(mbc_pkg::MBC_OFF_STATUS, 32'h0000_0202);
		rd_chk(mbc_pkg::MBC_OFF_BLKDONE, 32'h0);
		summarize();
	end
endmodule

bind mbc_media_block_coprocessor mbc_chk chk_u (
	.ref_clk_in(ref_clk_in),
	.reset_n_in(reset_n_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.irq_out(irq_out)
);
